// ### inc/rxds_pkg.sv
/*
 * constants and types for the receive descriptor status builder.
 * assumes a 40 mhz ref_clk that oversamples the mii receive clock.
 */
package rxds_pkg;

    // ------------------------------------------------------------
    // status word bit positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_CRC_ERR = 1;
    localparam int unsigned BIT_DRIBBLE = 2;
    localparam int unsigned BIT_PHY_ERR = 3;
    localparam int unsigned BIT_WDOG = 4;
    localparam int unsigned BIT_FRAME_TYPE = 5;
    localparam int unsigned BIT_LATE_COL = 6;
    localparam int unsigned BIT_SEVEN = 7;
    localparam int unsigned BIT_ZERO = 0;
    localparam int unsigned BIT_LAST_DESC = 8;
    localparam int unsigned BIT_ERR_SUM = 15;
    localparam logic [15:0] STATUS_RST = 16'h0000;

    // ------------------------------------------------------------
    // frame layout and limits (byte counts include fcs)
    // ------------------------------------------------------------
    localparam logic [13:0] OFF_LT_HI = 14'h000C;
    localparam logic [13:0] OFF_LT_LO = 14'h000D;
    localparam logic [13:0] OFF_ET2_HI = 14'h0010;
    localparam logic [13:0] OFF_ET2_LO = 14'h0011;
    localparam logic [13:0] OFF_IP_STD = 14'h000E;
    localparam logic [13:0] OFF_IP_VLAN = 14'h0012;
    localparam logic [13:0] GIANT_STD = 14'h05EE;
    localparam logic [13:0] GIANT_VLAN = 14'h05F2;
    localparam logic [13:0] GIANT_2K = 14'h07D0;
    localparam logic [13:0] GIANT_JUMBO = 14'h233A;
    localparam logic [13:0] GIANT_JUMBO_VLAN = 14'h233E;
    localparam logic [13:0] WDOG_STD = 14'h0800;
    localparam logic [13:0] WDOG_JUMBO = 14'h2800;
    localparam logic [13:0] LATE_COL_BYTES = 14'h0040;
    localparam logic [15:0] LT_ETYPE_MIN = 16'h0600;
    localparam logic [15:0] TPID_VLAN = 16'h8100;
    localparam logic [15:0] ETYPE_IPV4 = 16'h0800;
    localparam logic [3:0] IP_VERSION4 = 4'h4;
    localparam logic [3:0] IHL_MIN = 4'h5;
    localparam logic [15:0] CSUM_GOOD = 16'hFFFF;

    // ------------------------------------------------------------
    // crc and mii coding
    // ------------------------------------------------------------
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
    localparam logic [3:0] NIB_PREAMBLE = 4'h5;
    localparam logic [3:0] NIB_SFD_HI = 4'hD;

    // synchroniser lane positions
    localparam int unsigned SYN_CLK = 0;
    localparam int unsigned SYN_DV = 1;
    localparam int unsigned SYN_ER = 2;
    localparam int unsigned SYN_COL = 3;
    localparam int unsigned SYN_D0 = 4;
    localparam logic [7:0] SYN_RST = 8'h00;

    typedef enum logic [1:0] {
        RXDS_IDLE,
        RXDS_PRE,
        RXDS_DATA
    } rxds_phase_type;

endpackage

// ### inc/rxds_link_if.sv
/*
 * byte stream from the mii front end to the status builder.
 * assumes both ends run on ref_clk.
 */
interface rxds_link_if;
    logic byte_stb;
    logic [7:0] byte_data;
    logic frame_start;
    logic frame_end;
    logic odd_nib;
    logic er_seen;
    logic col;

    modport front (
        output byte_stb, byte_data, frame_start, frame_end, odd_nib, er_seen, col
    );
    modport back (
        input byte_stb, byte_data, frame_start, frame_end, odd_nib, er_seen, col
    );
endinterface

// ### src/rxds_mii_rx.sv
/*
 * mii receive front end: synchronises the pins, finds the sfd and
 * assembles bytes. assumes the mii clock is far slower than ref_clk.
 */
module rxds_mii_rx
    import rxds_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic mii_rx_clk,
    input wire logic mii_rx_dv,
    input wire logic mii_rx_er,
    input wire logic [3:0] mii_rxd,
    input wire logic mii_col,
    rxds_link_if.front lnk
);

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] stab;
        rxds_phase_type ph;
        logic [3:0] lo;
        logic half;
        logic byte_stb;
        logic [7:0] byte_data;
        logic frame_start;
        logic frame_end;
        logic odd_nib;
        logic er_seen;
    } rxds_fe_type;

    rxds_fe_type r;
    rxds_fe_type n;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // sampling on the falling link edge: data is mid-bit there, so the
    // equal sync latency of clock and data lanes cannot skew it
    always_comb begin
        logic [7:0] agree;
        logic fall;
        logic dv;
        logic [3:0] nib;
        agree = 8'h00;
        fall = 1'b0;
        dv = 1'b0;
        nib = 4'h0;
        n = r;
        n.s1 = {mii_rxd, mii_col, mii_rx_er, mii_rx_dv, mii_rx_clk};
        n.s2 = r.s1;
        n.s3 = r.s2;
        agree = ~(r.s2 ^ r.s3);
        n.stab = (agree & r.s3) | (~agree & r.stab);
        fall = r.stab[SYN_CLK] & ~n.stab[SYN_CLK];
        dv = n.stab[SYN_DV];
        nib = n.stab[SYN_D0 +: 4];
        n.byte_stb = 1'b0;
        n.frame_start = 1'b0;
        n.frame_end = 1'b0;
        n.er_seen = fall & dv & n.stab[SYN_ER];
        case (r.ph)
            RXDS_IDLE: begin
                if (fall && dv) begin
                    n.ph = RXDS_PRE;
                    n.lo = nib;
                end
            end
            RXDS_PRE: begin
                if (fall) begin
                    if (!dv) begin
                        n.ph = RXDS_IDLE;
                        // aborted preamble: lets the builder drop a stale rx error
                        n.frame_end = 1'b1;
                    end else if (nib == NIB_SFD_HI && r.lo == NIB_PREAMBLE) begin
                        n.ph = RXDS_DATA;
                        n.frame_start = 1'b1;
                        n.half = 1'b0;
                    end
                    n.lo = nib;
                end
            end
            RXDS_DATA: begin
                if (fall) begin
                    if (!dv) begin
                        n.frame_end = 1'b1;
                        n.odd_nib = r.half;
                        n.ph = RXDS_IDLE;
                    end else if (r.half) begin
                        n.byte_stb = 1'b1;
                        n.byte_data = {nib, r.lo};
                        n.half = 1'b0;
                    end else begin
                        n.lo = nib;
                        n.half = 1'b1;
                    end
                end
            end
            default: begin
                n.ph = RXDS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r <= '{s1: SYN_RST, s2: SYN_RST, s3: SYN_RST, stab: SYN_RST,
                   ph: RXDS_IDLE, lo: 4'h0, half: 1'b0, byte_stb: 1'b0,
                   byte_data: 8'h00, frame_start: 1'b0, frame_end: 1'b0,
                   odd_nib: 1'b0, er_seen: 1'b0};
        end else begin
            r <= n;
        end
    end

    // outputs toward the status builder
    assign lnk.byte_stb = r.byte_stb;
    assign lnk.byte_data = r.byte_data;
    assign lnk.frame_start = r.frame_start;
    assign lnk.frame_end = r.frame_end;
    assign lnk.odd_nib = r.odd_nib;
    assign lnk.er_seen = r.er_seen;
    assign lnk.col = r.stab[SYN_COL];

endmodule

// ### src/rxds_status.sv
/*
 * builds the low status bits, last-descriptor and error summary bits
 * of the receive descriptor status word at the end of each frame.
 * assumes config, timestamp and address-filter inputs on ref_clk.
 */

// What this block does
// - with timestamping, bit 7 shows a timestamp snapshot was written
// - type-one checksum: bit 7 set when ipv4 header checksum mismatches
// - type-one checksum: bit 7 also set for any non-ipv4 frame
// - otherwise bit 7 flags giant frames: 1518, 1522 vlan, 2000 in 2k mode
// - jumbo enabled: giant only above 9018 bytes, 9022 with vlan
// - bit 6 flags a late collision during half-duplex reception
// - bit 5 set when length/type is 1536 or more, else cleared
// - bit 4 flags watchdog expiry; the frame is truncated there
// - bit 3 flags rx error seen while data valid during the frame
// - bit 2 flags an odd nibble count, only in mii mode
// - bit 1 flags a bad frame check sequence, on the last descriptor
// - timestamping or type-two offload: bit 0 says extended status written
// - type-two offload: bit 0 set even when the engine skips a frame
// - otherwise bit 0 set on upper address match, cleared on register 0
// - bit 8 marks the descriptor holding the end of the frame
// - bit 15 ors crc, rx error, watchdog, late collision, bit 7 and others
module rxds_status
    import rxds_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic mii_rx_clk,
    input wire logic mii_rx_dv,
    input wire logic mii_rx_er,
    input wire logic [3:0] mii_rxd,
    input wire logic mii_col,
    input wire logic cfg_ts_present,
    input wire logic cfg_csum_type1,
    input wire logic cfg_csum_type2,
    input wire logic cfg_jumbo_en,
    input wire logic cfg_2k_en,
    input wire logic cfg_half_duplex,
    input wire logic cfg_mii_mode,
    input wire logic ts_snapshot_done,
    input wire logic da_match_upper,
    input wire logic other_err,
    output logic [15:0] desc_status_r,
    output logic desc_wb_r,
    output logic frame_trunc_r
);

    typedef struct packed {
        logic in_frame;
        logic [13:0] cnt;
        logic [31:0] crc;
        logic [15:0] lt;
        logic [15:0] et2;
        logic [3:0] ihl;
        logic ver4;
        logic [7:0] hi;
        logic [15:0] csum;
        logic trunc;
        logic late_col;
        logic phy_err;
        logic [15:0] status;
        logic wb;
    } rxds_st_type;

    rxds_st_type r;
    rxds_st_type n;

    rxds_link_if lnk ();

    rxds_mii_rx u_front (
        .ref_clk(ref_clk),
        .rst(rst),
        .mii_rx_clk(mii_rx_clk),
        .mii_rx_dv(mii_rx_dv),
        .mii_rx_er(mii_rx_er),
        .mii_rxd(mii_rxd),
        .mii_col(mii_col),
        .lnk(lnk.front)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // reflected crc-32, one byte lsb first
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] x;
        x = c;
        for (int i = 0; i < 8; i++) begin
            if (x[0] ^ d[i]) begin
                x = (x >> 1) ^ CRC_POLY;
            end else begin
                x = x >> 1;
            end
        end
        return x;
    endfunction

    // ones-complement add with end-around carry
    function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0] + {15'h0000, s[16]};
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic vlan;
        logic ipv4;
        logic [13:0] ip_off;
        logic [13:0] rel;
        logic [13:0] wd_lim;
        logic [13:0] giant_lim;
        logic giant;
        logic csum_err;
        logic [15:0] st;
        vlan = (r.lt == TPID_VLAN);
        ipv4 = vlan ? (r.et2 == ETYPE_IPV4) : (r.lt == ETYPE_IPV4);
        ip_off = vlan ? OFF_IP_VLAN : OFF_IP_STD;
        rel = r.cnt - ip_off;
        wd_lim = cfg_jumbo_en ? WDOG_JUMBO : WDOG_STD;
        giant_lim = 14'h0000;
        giant = 1'b0;
        csum_err = 1'b0;
        st = STATUS_RST;
        n = r;
        n.wb = 1'b0;

        // a new frame restarts every accumulator except the rx error flag
        if (lnk.frame_start) begin
            n.in_frame = 1'b1;
            n.cnt = 14'h0000;
            n.crc = CRC_INIT;
            n.lt = 16'h0000;
            n.et2 = 16'h0000;
            n.ihl = 4'h0;
            n.ver4 = 1'b0;
            n.csum = 16'h0000;
            n.trunc = 1'b0;
            n.late_col = 1'b0;
        end else if (lnk.byte_stb && r.in_frame) begin
            if (r.cnt >= wd_lim) begin
                n.trunc = 1'b1;
            end else begin
                n.cnt = r.cnt + 14'h0001;
                n.crc = crc_byte(r.crc, lnk.byte_data);
                if (r.cnt == OFF_LT_HI) n.lt[15:8] = lnk.byte_data;
                if (r.cnt == OFF_LT_LO) n.lt[7:0] = lnk.byte_data;
                if (r.cnt == OFF_ET2_HI) n.et2[15:8] = lnk.byte_data;
                if (r.cnt == OFF_ET2_LO) n.et2[7:0] = lnk.byte_data;
                // ip header words summed while inside the header length
                if (r.cnt >= ip_off && r.cnt > OFF_LT_LO &&
                    (rel == 14'h0000 || rel < {8'h00, r.ihl, 2'b00})) begin
                    if (rel == 14'h0000) begin
                        n.ihl = lnk.byte_data[3:0];
                        n.ver4 = (lnk.byte_data[7:4] == IP_VERSION4);
                    end
                    if (!rel[0]) begin
                        n.hi = lnk.byte_data;
                    end else begin
                        n.csum = oc_add(r.csum, {r.hi, lnk.byte_data});
                    end
                end
            end
        end

        // late collision: collision past the slot time, half duplex only
        if (r.in_frame && cfg_half_duplex && lnk.col && r.cnt >= LATE_COL_BYTES) begin
            n.late_col = 1'b1;
        end

        // rx error may arrive in the preamble, so it is kept until write-back
        if (lnk.er_seen) begin
            n.phy_err = 1'b1;
        end

        // ------------------------------------------------------------
        // end of frame: compose and write back
        // ------------------------------------------------------------
        if (lnk.frame_end && r.in_frame) begin
            if (cfg_jumbo_en) begin
                giant_lim = vlan ? GIANT_JUMBO_VLAN : GIANT_JUMBO;
            end else if (cfg_2k_en) begin
                giant_lim = GIANT_2K;
            end else begin
                giant_lim = vlan ? GIANT_VLAN : GIANT_STD;
            end
            giant = (r.cnt > giant_lim);
            // non-ipv4 and short or malformed headers all report here
            csum_err = !ipv4 || !r.ver4 || r.ihl < IHL_MIN ||
                       r.cnt < ip_off + {8'h00, r.ihl, 2'b00} ||
                       r.csum != CSUM_GOOD;
            if (cfg_ts_present) begin
                st[BIT_SEVEN] = ts_snapshot_done;
            end else if (cfg_csum_type1) begin
                st[BIT_SEVEN] = csum_err;
            end else begin
                st[BIT_SEVEN] = giant;
            end
            st[BIT_LATE_COL] = r.late_col;
            st[BIT_FRAME_TYPE] = (r.lt >= LT_ETYPE_MIN);
            st[BIT_WDOG] = r.trunc;
            st[BIT_PHY_ERR] = n.phy_err;
            st[BIT_DRIBBLE] = cfg_mii_mode & lnk.odd_nib;
            st[BIT_CRC_ERR] = (r.crc != CRC_RESIDUE);
            // extended status covers skipped frames too, so it is constant
            if (cfg_ts_present || cfg_csum_type2) begin
                st[BIT_ZERO] = 1'b1;
            end else begin
                st[BIT_ZERO] = da_match_upper;
            end
            st[BIT_LAST_DESC] = 1'b1;
            st[BIT_ERR_SUM] = st[BIT_CRC_ERR] | st[BIT_PHY_ERR] | st[BIT_WDOG] |
                              st[BIT_LATE_COL] | st[BIT_SEVEN] | other_err;
            n.status = st;
            n.wb = 1'b1;
            n.in_frame = 1'b0;
            n.phy_err = 1'b0;
        end else if (!r.in_frame && !lnk.frame_start && lnk.frame_end) begin
            n.phy_err = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r <= '{in_frame: 1'b0, cnt: 14'h0000, crc: CRC_INIT, lt: 16'h0000,
                   et2: 16'h0000, ihl: 4'h0, ver4: 1'b0, hi: 8'h00, csum: 16'h0000,
                   trunc: 1'b0, late_col: 1'b0, phy_err: 1'b0, status: STATUS_RST,
                   wb: 1'b0};
        end else begin
            r <= n;
        end
    end

    // status word and ownership release leave together
    assign desc_status_r = r.status;
    assign desc_wb_r = r.wb;
    assign frame_trunc_r = r.trunc;

endmodule

// ### test/rxds_status_checker.sv
/*
 * assertions on the status word outputs of the status builder.
 * assumes it is bound onto rxds_status and sees only its ports.
 */
module rxds_status_checker
    import rxds_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cfg_ts_present,
    input wire logic cfg_csum_type2,
    input wire logic cfg_half_duplex,
    input wire logic cfg_mii_mode,
    input wire logic ts_snapshot_done,
    input wire logic da_match_upper,
    input wire logic other_err,
    input wire logic [15:0] desc_status_r,
    input wire logic desc_wb_r,
    input wire logic frame_trunc_r
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // write-back properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // short alias keeps the properties readable
    logic [15:0] s;
    assign s = desc_status_r;

    chk_wb_pulse: assert property (desc_wb_r |=> !desc_wb_r)
        else $error("write-back pulse wider than one cycle");
    chk_status_hold: assert property (!desc_wb_r |-> $stable(s))
        else $error("status word changed without write-back");
    chk_last_desc: assert property (desc_wb_r |-> s[BIT_LAST_DESC])
        else $error("last descriptor bit clear at write-back");
    chk_err_sum: assert property (desc_wb_r |-> s[BIT_ERR_SUM] ==
        (|{s[1], s[3], s[4], s[6], s[7], $past(other_err)}))
        else $error("error summary disagrees with error bits");
    chk_late_col_half: assert property (
        desc_wb_r && !$past(cfg_half_duplex) |-> !s[BIT_LATE_COL])
        else $error("late collision flagged in full duplex");
    chk_dribble_mii: assert property (
        desc_wb_r && !$past(cfg_mii_mode) |-> !s[BIT_DRIBBLE])
        else $error("dribble flagged outside mii mode");
    chk_ext_status: assert property (
        desc_wb_r && ($past(cfg_ts_present) || $past(cfg_csum_type2)) |-> s[BIT_ZERO])
        else $error("extended status bit clear");
    chk_ts_avail: assert property (
        desc_wb_r && $past(cfg_ts_present) |-> s[BIT_SEVEN] == $past(ts_snapshot_done))
        else $error("timestamp bit disagrees with snapshot");
    chk_addr_match: assert property (
        desc_wb_r && !$past(cfg_ts_present) && !$past(cfg_csum_type2)
        |-> s[BIT_ZERO] == $past(da_match_upper))
        else $error("address match bit wrong");
    chk_trunc_flag: assert property (desc_wb_r |-> s[BIT_WDOG] == frame_trunc_r)
        else $error("watchdog bit disagrees with truncation flag");
endmodule

bind rxds_status rxds_status_checker u_chk (
    .ref_clk(ref_clk), .rst(rst), .cfg_ts_present(cfg_ts_present),
    .cfg_csum_type2(cfg_csum_type2), .cfg_half_duplex(cfg_half_duplex),
    .cfg_mii_mode(cfg_mii_mode), .ts_snapshot_done(ts_snapshot_done),
    .da_match_upper(da_match_upper), .other_err(other_err),
    .desc_status_r(desc_status_r), .desc_wb_r(desc_wb_r), .frame_trunc_r(frame_trunc_r)
);

// ### test/rxds_phy_model.sv
/*
 * mii phy model: preamble, sfd, frame nibbles, error and collision.
 * assumes a receiver that takes nibbles on the falling clock edge.
 */
module rxds_phy_model
    import rxds_pkg::*;
(
    output logic mii_rx_clk,
    output logic mii_rx_dv,
    output logic mii_rx_er,
    output logic [3:0] mii_rxd,
    output logic mii_col
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // link driver
    // ----------------------------------------
    // clock rests low between frames, as a phy may stop it
    initial begin
        mii_rx_clk = 1'b0;
        mii_rx_dv = 1'b0;
        mii_rx_er = 1'b0;
        mii_rxd = 4'h0;
        mii_col = 1'b0;
    end

    // data changes half-way through the low phase, clear of the taking fall;
    // changing on that fall would hand the receiver the next nibble instead
    task automatic nib(logic [3:0] d, logic v, logic e, logic c);
        #50;
        mii_rxd = d;
        mii_rx_dv = v;
        mii_rx_er = e;
        mii_col = c;
        #50 mii_rx_clk = 1'b1;
        #100 mii_rx_clk = 1'b0;
    endtask

    // ea: byte index carrying rx error, ca: first byte of an 8-byte collision burst
    task automatic send(input logic [7:0] f[$], input bit odd, input int ea, input int ca);
        logic c;
        repeat (15) nib(NIB_PREAMBLE, 1'b1, 1'b0, 1'b0);
        nib(NIB_SFD_HI, 1'b1, 1'b0, 1'b0);
        foreach (f[i]) begin
            c = ca >= 0 && i >= ca && i < ca + 8;
            nib(f[i][3:0], 1'b1, i == ea, c);
            nib(f[i][7:4], 1'b1, i == ea, c);
        end
        if (odd) nib(4'hA, 1'b1, 1'b0, 1'b0);
        // released data shows the inverse so stale nibbles never look valid
        nib(~mii_rxd, 1'b0, 1'b0, 1'b0);
    endtask
endmodule

// ### test/test_rxds_status.sv
/*
 * self-checking bench for the status builder.
 * assumes the phy model drives the mii pins and the checker is bound.
 */
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module test_rxds_status
    import rxds_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, rst, ck, dv, er, col, ts_done, da_up, oth, wb, trunc;
    logic [3:0] rxd;
    logic [6:0] cfg; // ts, type1, type2, jumbo, 2k, half, mii
    logic [15:0] st;
    logic [7:0] f[$];
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;

    rxds_phy_model u_phy (.mii_rx_clk(ck), .mii_rx_dv(dv), .mii_rx_er(er), .mii_rxd(rxd),
        .mii_col(col));
    rxds_status u_dut (.ref_clk(ref_clk), .rst(rst), .mii_rx_clk(ck), .mii_rx_dv(dv),
        .mii_rx_er(er), .mii_rxd(rxd), .mii_col(col), .cfg_ts_present(cfg[6]),
        .cfg_csum_type1(cfg[5]), .cfg_csum_type2(cfg[4]), .cfg_jumbo_en(cfg[3]),
        .cfg_2k_en(cfg[2]), .cfg_half_duplex(cfg[1]), .cfg_mii_mode(cfg[0]),
        .ts_snapshot_done(ts_done), .da_match_upper(da_up), .other_err(oth),
        .desc_status_r(st), .desc_wb_r(wb), .frame_trunc_r(trunc));

    // ----------------------------------------
    // clock, timeout and verdict
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // two long 2049-byte frames dominate the run time
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 95000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (n_errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------
    // frame builder and transfer
    // ----------------------------------------
    // n bytes incl fcs; optional ipv4 header with good or bad checksum
    task automatic mk(int n, logic [15:0] lt, bit ip, bit badc, bit badf);
        logic [31:0] c;
        logic [31:0] s;
        f = {};
        for (int i = 0; i < n - 4; i++) f.push_back(8'(i * 7 + 1));
        f[12] = lt[15:8];
        f[13] = lt[7:0];
        if (ip) begin
            f[14] = 8'h45;
            f[24] = 8'h00;
            f[25] = 8'h00;
            s = 0;
            for (int i = 14; i < 34; i += 2) s += {16'h0000, f[i], f[i + 1]};
            s = (s & 32'h0000FFFF) + (s >> 16);
            s = (s & 32'h0000FFFF) + (s >> 16);
            s = ~s ^ 32'(badc);
            f[24] = s[15:8];
            f[25] = s[7:0];
        end
        c = CRC_INIT;
        foreach (f[i]) begin
            c ^= {24'h000000, f[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        end
        c = ~c ^ 32'(badf);
        for (int i = 0; i < 4; i++) f.push_back(c[8 * i +: 8]);
    endtask

    task automatic set(logic [6:0] c, logic t, logic d, logic o);
        @(posedge ref_clk);
        #1;
        cfg = c;
        ts_done = t;
        da_up = d;
        oth = o;
    endtask

    // send one frame, then compare the written status with the expected one
    task automatic run(int n, logic [15:0] lt, bit ip, bit bc, bit bf, bit odd, int ea,
        int ca, bit e7, bit e0);
        logic [15:0] e;
        logic wd;
        int k;
        mk(n, lt, ip, bc, bf);
        wd = n > 2048 && !cfg[3];
        e = 16'h0100;
        e[7] = e7;
        e[0] = e0;
        e[5] = lt >= 16'h0600;
        e[4] = wd;
        e[3] = ea >= 0;
        e[2] = odd && cfg[0];
        e[1] = bf;
        e[6] = cfg[1] && ca >= 64;
        e[15] = |{e[1], e[3], e[4], e[6], e[7], oth};
        u_phy.send(f, odd, ea, ca);
        k = 0;
        do begin
            @(posedge ref_clk);
            #1;
            k++;
        end while (wb !== 1'b1 && k < 40);
        `CHK("wb", 1'b1, wb)
        // crc of a truncated frame is left open, so bit 1 is masked there
        `CHK("status", e, st & ~(16'(wd) << 1))
        `CHK("trunc", wd, trunc)
        @(posedge ref_clk);
        #1;
        `CHK("pulse", 1'b0, wb)
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        cfg = 7'h00;
        ts_done = 1'b0;
        da_up = 1'b0;
        oth = 1'b0;
        rst = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1 rst = 1'b0;
        `CHK("reset status", 16'h0000, st)
        repeat (4) @(posedge ref_clk);
        set(7'h01, 0, 1, 0);
        run(64, 16'h0600, 0, 0, 0, 0, -1, -1, 0, 1);
        set(7'h01, 0, 0, 0);
        run(65, 16'h05FF, 0, 0, 0, 1, -1, -1, 0, 0);
        set(7'h00, 0, 0, 0);
        run(64, 16'h05FF, 0, 0, 0, 1, -1, -1, 0, 0);
        run(64, 16'h0800, 0, 0, 1, 0, -1, -1, 0, 0);
        run(64, 16'h0800, 0, 0, 0, 0, 20, -1, 0, 0);
        set(7'h00, 0, 0, 1);
        run(64, 16'h0800, 0, 0, 0, 0, -1, -1, 0, 0);
        set(7'h02, 0, 0, 0);
        run(80, 16'h0800, 0, 0, 0, 0, -1, 70, 0, 0);
        run(80, 16'h0800, 0, 0, 0, 0, -1, 10, 0, 0);
        set(7'h00, 0, 0, 0);
        run(80, 16'h0800, 0, 0, 0, 0, -1, 70, 0, 0);
        for (int t = 0; t < 2; t++) begin
            set(7'h40, t[0], 0, 0);
            run(64, 16'h0800, 0, 0, 0, 0, -1, -1, t[0], 1);
        end
        set(7'h20, 0, 1, 0);
        run(64, 16'h0800, 1, 0, 0, 0, -1, -1, 0, 1);
        run(64, 16'h0800, 1, 1, 0, 0, -1, -1, 1, 1);
        run(64, 16'h86DD, 0, 0, 0, 0, -1, -1, 1, 1);
        set(7'h10, 0, 0, 0);
        run(64, 16'h86DD, 0, 0, 0, 0, -1, -1, 0, 1);
        // a second reset in mid-run clears the held status
        @(posedge ref_clk);
        #1 rst = 1'b1;
        @(posedge ref_clk);
        #1;
        `CHK("mid reset", 16'h0000, st)
        rst = 1'b0;
        set(7'h04, 0, 0, 0);
        run(2049, 16'h0800, 0, 0, 0, 0, -1, -1, 1, 0);
        set(7'h08, 0, 0, 0);
        run(2049, 16'h0800, 0, 0, 0, 0, -1, -1, 0, 0);
        stop_test();
    end
endmodule
